// >>> common/hs_diag_pkg.sv
// Purpose: Shared constants for the high-side fault diagnostics block
// Assumes: Core clock of 40 MHz
// Notes:   Filter and delay times are given in ns; cycle counts derive from them
package hs_diag_pkg;
  localparam int          NUM_CH       = 8;
  localparam int          FAULT_W      = 2;
  localparam int          FAULT_REG_W  = 16;
  localparam int          NUM_PWM_CH   = 3;
  localparam int          PWM_FIRST_CH = 5;     // Channels 5-7 counted from zero
  localparam logic [1:0]  CODE_NONE    = 2'h0;
  localparam logic [1:0]  CODE_OPEN    = 2'h1;
  localparam logic [1:0]  CODE_SHORT   = 2'h2;
  localparam logic [1:0]  CODE_OVC     = 2'h3;
  localparam logic [15:0] FAULT_RESET  = 16'h0000;
  localparam logic [15:0] FAULT_THERM  = 16'hFFFF;
  localparam logic [7:0]  MODE_RESET   = 8'h00; // Non-latching after reset
  localparam logic [7:0]  PROT_RESET   = 8'hFF; // Shut-off protection on after reset
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          TFILT_NS     = 100000;
  localparam int          TDEL_NS      = 10000;
  localparam int          TRES_NS      = 5000000;
  // Least times round up, none below one cycle
  localparam int          TFILT_CYC = (TFILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TDEL_CYC  = (TDEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TRES_CYC  = (TRES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W     = 20;
endpackage

// >>> rtl/hs_fault_diag.sv
// Purpose: Per-channel high-side fault diagnosis, overcurrent shut-off and restart
// Assumes: Serial framing lives outside; command bytes arrive on the link clock
// Notes:   Comparator and chip-select pins are asynchronous and synchronised here
`timescale 1ns/1ps
module hs_fault_diag
  import hs_diag_pkg::*;
#(
  parameter int TFILT = hs_diag_pkg::TFILT_CYC,
  parameter int TDEL  = hs_diag_pkg::TDEL_CYC,
  parameter int TRES  = hs_diag_pkg::TRES_CYC
) (
  input  wire logic                           clk_in,
  input  wire logic                           resetn_in,
  input  wire logic                           clk_en_in,
  input  wire logic                           link_clk_in,
  input  wire logic                           link_resetn_in,
  input  wire logic                           cmd_valid_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] cmd_output_on_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] cmd_latch_mode_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] cmd_prot_en_in,
  input  wire logic                           chip_select_n_in,
  input  wire logic [hs_diag_pkg::NUM_PWM_CH-1:0] parallel_pwm_inputs_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] source_terminal_sense_open_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] source_terminal_sense_short_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] overcurrent_threshold_in,
  input  wire logic [hs_diag_pkg::NUM_CH-1:0] thermal_shutdown_in,
  output logic [hs_diag_pkg::FAULT_REG_W-1:0] fault_reg_out,
  output logic [hs_diag_pkg::NUM_CH-1:0]      channel_on_out,
  output logic [hs_diag_pkg::NUM_CH-1:0]      current_limit_out,
  output logic [hs_diag_pkg::NUM_CH-1:0]      shutoff_out
);
  import hs_diag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: command capture and handshake toward the core clock

  logic [NUM_CH-1:0] lk_on;
  logic [NUM_CH-1:0] lk_latch;
  logic [NUM_CH-1:0] lk_prot;
  logic              lk_toggle;
  logic              lk_ack_meta;
  logic              lk_ack_sync;
  logic              lk_busy;
  logic              core_ack;

  // A command word is held stable until the core acknowledges it; a byte that
  // arrives while busy is dropped, which the host avoids by spacing transfers
  always_ff @(posedge link_clk_in or negedge link_resetn_in)
  begin
    if (!link_resetn_in)
    begin
      lk_on     <= '0;
      lk_latch  <= MODE_RESET;
      lk_prot   <= PROT_RESET;
      lk_toggle <= 1'b0;
    end
    else if (cmd_valid_in && !lk_busy)
    begin
      lk_on     <= cmd_output_on_in;
      lk_latch  <= cmd_latch_mode_in;
      lk_prot   <= cmd_prot_en_in;
      lk_toggle <= ~lk_toggle;
    end
  end

  // Acknowledge toggle returned from the core domain
  always_ff @(posedge link_clk_in or negedge link_resetn_in)
  begin
    if (!link_resetn_in)
    begin
      lk_ack_meta <= 1'b0;
      lk_ack_sync <= 1'b0;
    end
    else
    begin
      lk_ack_meta <= core_ack;
      lk_ack_sync <= lk_ack_meta;
    end
  end

  assign lk_busy = lk_toggle ^ lk_ack_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers

  logic                  req_sync;
  logic                  cs_n_s;
  logic                  cs_n_d;
  logic [NUM_PWM_CH-1:0] pwm_s;
  logic [NUM_PWM_CH-1:0] pwm_d;
  logic [NUM_CH-1:0]     open_s;
  logic [NUM_CH-1:0]     short_s;
  logic [NUM_CH-1:0]     ovc_s;
  logic [NUM_CH-1:0]     therm_s;

  hs_sync2 #(.W(1)) u_sync_req (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (lk_toggle),
    .sync_out  (req_sync)
  );

  hs_sync2 #(.W(1 + NUM_PWM_CH + 4 * NUM_CH)) u_sync_pins (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  ({~chip_select_n_in, parallel_pwm_inputs_in, source_terminal_sense_open_in,
                 source_terminal_sense_short_in, overcurrent_threshold_in,
                 thermal_shutdown_in}),
    .sync_out  ({cs_n_s, pwm_s, open_s, short_s, ovc_s, therm_s})
  );

  logic cs_fall;
  logic cs_rise;
  logic cmd_take;
  logic [NUM_PWM_CH-1:0] pwm_rise;

  // Edge history on synchronised pins only; cs_n_s holds select active-high
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cs_n_d <= 1'b0;
      pwm_d  <= '0;
    end
    else if (clk_en_in)
    begin
      cs_n_d <= cs_n_s;
      pwm_d  <= pwm_s;
    end
  end

  assign cs_fall  = clk_en_in && cs_n_s && !cs_n_d;
  assign cs_rise  = clk_en_in && !cs_n_s && cs_n_d;
  assign pwm_rise = pwm_s & ~pwm_d;
  assign cmd_take = clk_en_in && (req_sync != core_ack);

  ////////////////////////////////////////////////////////////////////////////////
  // Command registers in the core domain

  logic [NUM_CH-1:0] cmd_on;
  logic [NUM_CH-1:0] latch_mode;
  logic [NUM_CH-1:0] prot_en;
  logic [NUM_CH-1:0] zero_seen;
  logic              byte_valid;
  logic              byte_valid_prev;

  // Word is stable in the link domain while the toggles differ
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      core_ack   <= 1'b0;
      cmd_on     <= '0;
      latch_mode <= MODE_RESET;
      prot_en    <= PROT_RESET;
    end
    else if (cmd_take)
    begin
      core_ack   <= req_sync;
      cmd_on     <= lk_on;
      latch_mode <= lk_latch;
      prot_en    <= lk_prot;
    end
  end

  // Valid-byte bookkeeping per transfer; set wins over the end-of-frame clear
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      byte_valid      <= 1'b0;
      byte_valid_prev <= 1'b0;
      zero_seen       <= '0;
    end
    else if (clk_en_in)
    begin
      if (cmd_take)
        byte_valid <= 1'b1;
      else if (cs_rise)
        byte_valid <= 1'b0;
      if (cs_rise)
      begin
        byte_valid_prev <= byte_valid || cmd_take;
        zero_seen       <= (byte_valid || cmd_take) ? ~cmd_on : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel protection and diagnosis

  logic [NUM_CH-1:0] oc_trip;
  logic [NUM_CH-1:0] off_open_q;
  logic [NUM_CH-1:0] off_short_q;
  logic [NUM_CH-1:0] res_done;
  logic [NUM_CH-1:0] restart;
  logic [NUM_CH-1:0] driving;
  logic [1:0]        field [NUM_CH];
  logic              therm_snap;

  assign driving = cmd_on & ~shutoff_out;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      logic pwm_restart;

      // Overcurrent filter only while driving with protection on
      hs_persist_timer #(.W(CNT_W), .LIMIT(TDEL)) u_tdel (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .enable_in   (clk_en_in),
        .cond_in     (driving[g] && prot_en[g] && ovc_s[g]),
        .expired_out (oc_trip[g])
      );

      // Off-state filters for latching mode
      hs_persist_timer #(.W(CNT_W), .LIMIT(TFILT)) u_tfilt_open (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .enable_in   (clk_en_in),
        .cond_in     (!driving[g] && open_s[g]),
        .expired_out (off_open_q[g])
      );

      hs_persist_timer #(.W(CNT_W), .LIMIT(TFILT)) u_tfilt_short (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .enable_in   (clk_en_in),
        .cond_in     (!driving[g] && short_s[g]),
        .expired_out (off_short_q[g])
      );

      // Restart delay runs while the channel sits shut off
      hs_persist_timer #(.W(CNT_W), .LIMIT(TRES)) u_tres (
        .clk_in      (clk_in),
        .resetn_in   (resetn_in),
        .enable_in   (clk_en_in),
        .cond_in     (shutoff_out[g]),
        .expired_out (res_done[g])
      );

      if (g >= PWM_FIRST_CH)
      begin : g_pwm
        assign pwm_restart = clk_en_in && pwm_rise[g - PWM_FIRST_CH];
      end
      else
      begin : g_nopwm
        assign pwm_restart = 1'b0;
      end

      // Zero then one on the output bit over two valid transfers
      assign restart[g] = res_done[g]
                        || (cs_rise && byte_valid && byte_valid_prev
                            && zero_seen[g] && cmd_on[g])
                        || pwm_restart;

      // Shut-off latch; a new trip in the restart cycle wins
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          shutoff_out[g] <= 1'b0;
        else if (clk_en_in)
        begin
          if (oc_trip[g])
            shutoff_out[g] <= 1'b1;
          else if (restart[g])
            shutoff_out[g] <= 1'b0;
        end
      end

      // Fault field: overcurrent highest, then sampled or latched off-state faults
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          field[g] <= CODE_NONE;
        else if (clk_en_in)
        begin
          if (oc_trip[g])
            field[g] <= CODE_OVC;
          else if (field[g] == CODE_OVC && !(cs_rise && byte_valid))
            field[g] <= CODE_OVC;
          else if (!latch_mode[g])
          begin
            // Fresh snapshot at each select fall, nothing carried over
            if (cs_fall)
            begin
              if (!driving[g] && short_s[g])
                field[g] <= CODE_SHORT;
              else if (!driving[g] && open_s[g])
                field[g] <= CODE_OPEN;
              else
                field[g] <= CODE_NONE;
            end
            else if (cs_rise && byte_valid)
              field[g] <= CODE_NONE;
          end
          else if (off_short_q[g] && field[g] == CODE_NONE)
            field[g] <= CODE_SHORT;
          else if (off_open_q[g] && field[g] == CODE_NONE)
            field[g] <= CODE_OPEN;
          else if (cs_rise && byte_valid)
            field[g] <= CODE_NONE;
        end
      end

      // Without protection the driver stays on and limits current linearly
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          current_limit_out[g] <= 1'b0;
        else if (clk_en_in)
          current_limit_out[g] <= driving[g] && !prot_en[g] && ovc_s[g];
      end

      assign fault_reg_out[FAULT_W*g +: FAULT_W] = therm_snap ? FAULT_THERM[FAULT_W*g +: FAULT_W]
                                                              : field[g];
    end
  endgenerate

  // Thermal state is sampled at select fall and cleared by a valid transfer
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      therm_snap <= 1'b0;
    else if (clk_en_in)
    begin
      if (cs_fall)
        therm_snap <= |therm_s;
      else if (cs_rise && byte_valid)
        therm_snap <= 1'b0;
    end
  end

  // Gate drive registered so it never glitches
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      channel_on_out <= '0;
    else if (clk_en_in)
      channel_on_out <= driving;
  end
endmodule

// >>> rtl/hs_persist_timer.sv
// Purpose: Counts how long a condition has held and flags expiry
// Assumes: Condition is synchronous to clk_in
// Notes:   Counter restarts whenever the condition drops
`timescale 1ns/1ps
module hs_persist_timer #(
  parameter int W     = 20,
  parameter int LIMIT = 4000
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic enable_in,
  input  wire logic cond_in,
  output logic      expired_out
);
  logic [W-1:0] count;

  // Saturating count while the condition holds
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count <= '0;
    else if (enable_in)
    begin
      if (!cond_in)
        count <= '0;
      else if (count != W'(LIMIT))
        count <= count + W'(1);
    end
  end

  assign expired_out = cond_in && (count == W'(LIMIT));
endmodule

// >>> rtl/hs_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of level signals
// Assumes: Inputs are asynchronous to clk_in
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module hs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // Two stages; the clock enable is not applied so edges are never half-seen
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> testbench/hs_fault_diag_assertions.sv
// Purpose: Port-level checks for the high-side fault block
// Assumes: Bound to every fault block, shortened counts handed on
// Notes:   Helper counters bound the filter and restart times
`timescale 1ns/1ps
module hs_fault_diag_checker
  import hs_diag_pkg::*;
#(
  parameter int TDEL = TDEL_CYC,
  parameter int TRES = TRES_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              chip_select_n_in,
  input  wire logic [NUM_CH-1:0] overcurrent_threshold_in,
  input  wire logic [NUM_CH-1:0] thermal_shutdown_in,
  input  wire logic [15:0]       fault_reg_out,
  input  wire logic [NUM_CH-1:0] channel_on_out,
  input  wire logic [NUM_CH-1:0] current_limit_out,
  input  wire logic [NUM_CH-1:0] shutoff_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic       cs_prev;
  logic [7:0] cs_age;
  ////////////////////////////////////////////////////////////////////////////////
  // Age of the last select edge; the register may only empty close to one
  always_ff @(posedge clk_in or negedge resetn_in)
    if (!resetn_in)
    begin
      cs_prev <= 1'b1;
      cs_age  <= 8'h00;
    end
    else
    begin
      cs_prev <= chip_select_n_in;
      cs_age  <= (chip_select_n_in != cs_prev) ? 8'h00 : cs_age + {7'h00, cs_age != 8'hFF};
    end
  a_reset_state: assert property (
    $rose(resetn_in) |-> fault_reg_out == FAULT_RESET && !(|channel_on_out) && !(|shutoff_out))
    else $error("outputs not idle after reset");
  a_therm_ones: assert property (
    $fell(chip_select_n_in) && (|thermal_shutdown_in) |-> ##[1:6] fault_reg_out == FAULT_THERM)
    else $error("thermal snapshot not all ones");
  a_off_when_shut: assert property (
    (|(shutoff_out & channel_on_out)) |=> !(|(shutoff_out & channel_on_out)))
    else $error("channel left on while shut off");
  a_clear_near_cs: assert property (
    $fell(|fault_reg_out) |-> cs_age <= 8'h06)
    else $error("fault register emptied away from a select edge");
  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel counters of overcurrent and shut-off duration
  for (genvar g = 0; g < NUM_CH; g++)
  begin : per_ch
    logic [15:0] ovc_cnt;
    logic [15:0] shut_cnt;
    always_ff @(posedge clk_in or negedge resetn_in)
      if (!resetn_in)
      begin
        ovc_cnt  <= 16'h0000;
        shut_cnt <= 16'h0000;
      end
      else
      begin
        ovc_cnt  <= overcurrent_threshold_in[g] ? ovc_cnt + 16'h0001 : 16'h0000;
        shut_cnt <= shutoff_out[g] ? shut_cnt + 16'h0001 : 16'h0000;
      end
    a_ovc_filter: assert property ($rose(shutoff_out[g]) |-> ovc_cnt >= TDEL)
      else $error("shut-off before the overcurrent filter time");
    a_ovc_code: assert property (
      $rose(shutoff_out[g]) |-> ##[0:1] fault_reg_out[2*g +: 2] == CODE_OVC)
      else $error("shut-off without overcurrent code");
    a_restart_bound: assert property (shut_cnt <= TRES + 4)
      else $error("automatic restart overdue");
    a_limit_only: assert property (
      current_limit_out[g] |-> !shutoff_out[g] && channel_on_out[g])
      else $error("current limit while shut off or off");
  end
  c_shutoff: cover property ($rose(|shutoff_out));
  c_limit: cover property ($rose(|current_limit_out));
  c_therm: cover property (fault_reg_out == FAULT_THERM);
endmodule

bind hs_fault_diag hs_fault_diag_checker #(.TDEL(TDEL), .TRES(TRES)) chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .chip_select_n_in(chip_select_n_in),
  .overcurrent_threshold_in(overcurrent_threshold_in),
  .thermal_shutdown_in(thermal_shutdown_in), .fault_reg_out(fault_reg_out),
  .channel_on_out(channel_on_out), .current_limit_out(current_limit_out),
  .shutoff_out(shutoff_out));

// >>> testbench/hs_fault_diag_test.sv
// Purpose: Directed tests of diagnosis, shut-off and restart
// Assumes: Shortened filter, delay and restart counts
// Notes:   Inputs move on falling clock edges only
`timescale 1ns/1ps
module hs_fault_diag_test;
  import hs_diag_pkg::*;
  localparam int TR = 200;
  logic        clk_in = 1'b0;
  logic        link_clk_in = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  open_s = 8'h00;
  logic [7:0]  short_s = 8'h00;
  logic [7:0]  ovc = 8'h00;
  logic [7:0]  therm = 8'h00;
  wire logic        cmd_v, cs_n;
  wire logic [7:0]  c_on, c_lat, c_prot, on_o, lim_o, shut_o;
  wire logic [2:0]  pwm;
  wire logic [15:0] fault;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 clk_in = ~clk_in;
  always #7.5 link_clk_in = ~link_clk_in;
  hs_host_model host (.clk_in(clk_in), .link_clk_in(link_clk_in), .cmd_valid_out(cmd_v),
    .cmd_on_out(c_on), .cmd_latch_out(c_lat), .cmd_prot_out(c_prot), .cs_n_out(cs_n),
    .pwm_out(pwm));
  hs_fault_diag #(.TFILT(8), .TDEL(4), .TRES(TR)) DUT (.clk_in(clk_in), .resetn_in(resetn),
    .clk_en_in(1'b1), .link_clk_in(link_clk_in), .link_resetn_in(resetn),
    .cmd_valid_in(cmd_v), .cmd_output_on_in(c_on), .cmd_latch_mode_in(c_lat),
    .cmd_prot_en_in(c_prot), .chip_select_n_in(cs_n), .parallel_pwm_inputs_in(pwm),
    .source_terminal_sense_open_in(open_s), .source_terminal_sense_short_in(short_s),
    .overcurrent_threshold_in(ovc), .thermal_shutdown_in(therm), .fault_reg_out(fault),
    .channel_on_out(on_o), .current_limit_out(lim_o), .shutoff_out(shut_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic check(input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a channel's shut-off flag, then compare it
  task automatic wait_shut(input int ch, input logic v, input int lim);
    int n;
    n = 0;
    while (shut_o[ch] !== v && n < lim)
    begin
      settle(1);
      n++;
    end
    check({15'h0000, shut_o[ch]}, {15'h0000, v});
  endtask
  task automatic print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far above the expected run of about eight hundred cycles
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    settle(16);
    resetn = 1'b1;
    settle(4);
    check(fault, FAULT_RESET);
    check({on_o, shut_o | lim_o}, 16'h0000);
    $display("test reset done");
    // Off channels snapshot at select fall; short beats open; ch8 is on
    host.frame(1'b1, 8'h80, 8'h00, 8'hFF);
    open_s = 8'h85;
    short_s = 8'h06;
    host.frame(1'b0, 8'h00, 8'h00, 8'h00);
    check(fault, 16'h0029);
    open_s = 8'h00;
    short_s = 8'h00;
    host.frame(1'b0, 8'h00, 8'h00, 8'h00);
    check(fault, 16'h0000);
    therm = 8'h10;
    host.frame(1'b0, 8'h00, 8'h00, 8'h00);
    check(fault, FAULT_THERM);
    // Thermal still present: only the valid transfer at select rise clears it
    host.frame(1'b1, 8'h00, 8'h00, 8'hFF);
    check(fault, 16'h0000);
    therm = 8'h00;
    $display("test snapshot done");
    // Latching: a short pulse is filtered, a long one is held after it ends
    host.frame(1'b1, 8'h00, 8'h01, 8'hFF);
    open_s = 8'h01;
    settle(4);
    open_s = 8'h00;
    settle(20);
    check(fault, 16'h0000);
    open_s = 8'h01;
    settle(25);
    open_s = 8'h00;
    settle(5);
    check(fault, 16'h0001);
    host.frame(1'b1, 8'h00, 8'h01, 8'hFF);
    check(fault, 16'h0000);
    // Latched short, written into the now empty field
    short_s = 8'h01;
    settle(25);
    short_s = 8'h00;
    settle(5);
    check(fault, 16'h0002);
    host.frame(1'b1, 8'h00, 8'h00, 8'hFF);
    check(fault, 16'h0000);
    $display("test latching done");
    // Overcurrent: glitch ignored, shut-off wins over open, auto restart
    host.frame(1'b1, 8'h01, 8'h00, 8'hFF);
    ovc = 8'h01;
    settle(2);
    ovc = 8'h00;
    settle(10);
    check({8'h00, shut_o}, 16'h0000);
    ovc = 8'h01;
    wait_shut(0, 1'b1, 20);
    settle(2);
    check({fault[1:0], 7'h00, on_o[0]}, {CODE_OVC, 8'h00});
    ovc = 8'h00;
    open_s = 8'h01;
    host.frame(1'b0, 8'h00, 8'h00, 8'h00);
    check({14'h0000, fault[1:0]}, {14'h0000, CODE_OVC});
    open_s = 8'h00;
    wait_shut(0, 1'b0, TR + 20);
    settle(2);
    check({fault[1:0], 7'h00, on_o[0]}, {CODE_OVC, 8'h01});
    host.frame(1'b1, 8'h00, 8'h00, 8'hFF);
    $display("test auto restart done");
    // Serial restart needs the zero-then-one pair of frames
    host.frame(1'b1, 8'h02, 8'h00, 8'hFF);
    ovc = 8'h02;
    wait_shut(1, 1'b1, 20);
    ovc = 8'h00;
    host.frame(1'b1, 8'h00, 8'h00, 8'hFF);
    check({15'h0000, shut_o[1]}, 16'h0001);
    host.frame(1'b1, 8'h02, 8'h00, 8'hFF);
    check({shut_o[1], on_o[1]}, 2'h1);
    $display("test serial restart done");
    // Parallel input rising edge restarts the sixth channel
    host.frame(1'b1, 8'h20, 8'h00, 8'hFF);
    ovc = 8'h20;
    wait_shut(5, 1'b1, 20);
    ovc = 8'h00;
    host.pwm_set(3'h1);
    check({15'h0000, shut_o[5]}, 16'h0000);
    host.pwm_set(3'h0);
    $display("test parallel restart done");
    // Protection off on the third channel: limit only, no code
    host.frame(1'b1, 8'h04, 8'h00, 8'hFB);
    ovc = 8'h04;
    settle(20);
    check({lim_o[2], shut_o[2], fault[5:4]}, 4'h8);
    ovc = 8'h00;
    settle(5);
    $display("test linear limit done");
    print_verdict();
  end
endmodule

// >>> testbench/hs_host_model.sv
// Purpose: Host side: select frames, command words, parallel inputs
// Assumes: Commands sent on the link clock, select on the core clock
// Notes:   Released command lines show the inverse word, not the old one
`timescale 1ns/1ps
module hs_host_model (
  input  wire logic clk_in,
  input  wire logic link_clk_in,
  output logic       cmd_valid_out,
  output logic [7:0] cmd_on_out,
  output logic [7:0] cmd_latch_out,
  output logic [7:0] cmd_prot_out,
  output logic       cs_n_out,
  output logic [2:0] pwm_out
);
  initial
  begin
    cmd_valid_out = 1'b0;
    {cmd_on_out, cmd_latch_out, cmd_prot_out} = 24'h0000FF;
    cs_n_out = 1'b1;
    pwm_out = 3'h0;
  end
  // One select frame, with a whole command word when v is set
  task automatic frame(input logic v, input logic [7:0] on, lat, prot);
    @(negedge clk_in) cs_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    if (v)
    begin
      @(negedge link_clk_in);
      {cmd_on_out, cmd_latch_out, cmd_prot_out} = {on, lat, prot};
      cmd_valid_out = 1'b1;
      @(negedge link_clk_in);
      cmd_valid_out = 1'b0;
      {cmd_on_out, cmd_latch_out, cmd_prot_out} = ~{on, lat, prot};
    end
    repeat (8) @(negedge clk_in);
    cs_n_out = 1'b1;
    // Gap keeps commands well over 200 ns apart
    repeat (10) @(negedge clk_in);
  endtask
  // Parallel inputs; a falling input is left to settle before any capture
  task automatic pwm_set(input logic [2:0] v);
    @(negedge clk_in) pwm_out = v;
    repeat (20) @(negedge clk_in);
  endtask
endmodule
